// ===== pkg/pes_pkg.sv
// Package for the performance event select and qualify block.
// Assumes one core clock; all strobes arrive synchronous to it.
package pes_pkg;

  // Event codes
  localparam logic [7:0] EV_FP_SIMD = 8'hCC;
  localparam logic [7:0] EV_MACRO = 8'hD0;
  localparam logic [7:0] EV_UOPS = 8'hD1;
  localparam logic [7:0] EV_RAT = 8'hD2;

  // Unit masks
  localparam logic [7:0] UM_TO_FP = 8'h01;
  localparam logic [7:0] UM_TO_SIMD = 8'h02;
  localparam logic [7:0] UM_ANY_TRANS = 8'h03;
  localparam logic [7:0] UM_DECODED = 8'h01;
  localparam logic [7:0] UM_SEQ_UOPS = 8'h02;
  localparam logic [7:0] UM_STACK_FOLD = 8'h04;
  localparam logic [7:0] UM_STACK_SYNC = 8'h08;
  localparam logic [7:0] UM_FLAG_STALL = 8'h01;
  localparam logic [7:0] UM_REG_STALL = 8'h02;
  localparam logic [7:0] UM_ROB_STALL = 8'h04;
  localparam logic [7:0] UM_SERIAL_STALL = 8'h08;

  // Widths
  localparam int COUNT_W = 48;
  localparam int UOP_W = 4;
  localparam int FLAG_W = 6;
  localparam int DELTA_W = 16;
  localparam int SP_W = 32;

  // Sequencer takes over above this many uops per instruction
  localparam logic [UOP_W-1:0] SEQ_UOP_LIMIT = 4'h4;
  localparam logic [FLAG_W-1:0] FLAGS_ALL = 6'h3F;

  // Reset values
  localparam logic [COUNT_W-1:0] COUNT_RST = 48'h0;
  localparam logic [DELTA_W-1:0] DELTA_RST = 16'h0;
  localparam logic [SP_W-1:0] SP_RST = 32'h0;
  localparam logic [FLAG_W-1:0] FLAG_RST = 6'h0;

  typedef enum logic [3:0] {
    SEL_NONE,
    SEL_TO_FP,
    SEL_TO_SIMD,
    SEL_ANY_TRANS,
    SEL_DECODED,
    SEL_SEQ_UOPS,
    SEL_STACK_FOLD,
    SEL_STACK_SYNC,
    SEL_FLAG_STALL,
    SEL_REG_STALL,
    SEL_ROB_STALL,
    SEL_SERIAL_STALL
  } pes_sel_t;

  typedef enum logic [1:0] {
    CLS_OTHER,
    CLS_FP,
    CLS_SIMD_INT
  } pes_cls_t;

  // One decoded macro-instruction per cycle at most
  typedef struct packed {
    logic valid;
    pes_cls_t cls;
    logic [UOP_W-1:0] uopCount;
    logic assist;
    logic stackAdjust;
    logic [DELTA_W-1:0] stackStep;
    logic stackSync;
    logic [FLAG_W-1:0] flagWrite;
    logic [FLAG_W-1:0] flagRead;
  } pes_decode_t;

  // Rename-stage stall levels, one cycle each
  typedef struct packed {
    logic renameStall;
    logic partialRegStall;
    logic robPortStall;
    logic scoreboardStall;
  } pes_stall_t;

endpackage

// ===== logic/pes_stack_delta.sv
// Stack delta tracker: folds implicit stack pointer steps into an offset.
// Assumes adjust and sync strobes are one-cycle and core-synchronous.
`timescale 1ns/1ps
module pes_stack_delta (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Decode strobes
  input wire logic stackAdjust,
  input wire logic [pes_pkg::DELTA_W-1:0] stackStep,
  input wire logic stackSync,
  // State
  output logic [pes_pkg::DELTA_W-1:0] stackDelta,
  output logic [pes_pkg::SP_W-1:0] stackPointer
);
  import pes_pkg::*;

  logic [DELTA_W-1:0] next_stackDelta;
  logic [SP_W-1:0] next_stackPointer;
  logic [SP_W-1:0] deltaWide;
  logic [DELTA_W-1:0] syncedDelta;

  // Sign-extend the offset before it is added to the pointer
  assign deltaWide = {{(SP_W-DELTA_W){stackDelta[DELTA_W-1]}}, stackDelta};
  // A step arriving with a sync lands in the fresh offset, not lost
  assign syncedDelta = stackAdjust ? stackStep : DELTA_RST;
  assign next_stackPointer = stackSync ?
                             SP_W'(stackPointer + deltaWide) : stackPointer;
  assign next_stackDelta = stackSync ? syncedDelta :
                           stackAdjust ? DELTA_W'(stackDelta + stackStep) :
                           stackDelta;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stackDelta <= DELTA_RST;
      stackPointer <= SP_RST;
    end else begin
      stackDelta <= next_stackDelta;
      stackPointer <= next_stackPointer;
    end
  end

endmodule

// ===== logic/pes_event_select.sv
// Event select and qualify logic for one core performance counter.
// Assumes decode and rename strobes are core-synchronous, one per cycle.
//
// Contract
// - Code CCH mask 02H counts the first SIMD integer op after an FP op.
// - Code CCH mask 03H counts each FP/SIMD integer switch either way.
// - Code D0H mask 01H counts every decoded macro-instruction.
// - Code D1H mask 02H counts uops delivered by the microcode sequencer.
// - The sequencer supplies uops above four per instruction or on assist.
// - Code D1H mask 04H counts decoded implicit stack adjusting ops.
// - Stack adjusting ops emit no pointer uop and update a delta register.
// - Code D1H mask 08H counts syncs adding the delta into the pointer.
// - Code D2H mask 01H counts stall cycles that include a flag stall.
// - A flag stall is a partial flag write then a read of untouched flags.
// - Code D2H mask 02H counts partial register latency cycles.
// - Code D2H mask 04H counts reorder buffer read port stall cycles.
// - Each retry cycle under a lasting read port stall counts again.
// - Code D2H mask 08H counts serialization scoreboard stall cycles.
// - Code CCH mask 01H counts the first FP op after a SIMD integer op.
`timescale 1ns/1ps
module pes_event_select (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Event selection
  input wire logic [7:0] evtCode,
  input wire logic [7:0] unitMask,
  input wire logic countEnable,
  // Core strobes
  input wire pes_pkg::pes_decode_t decode,
  input wire pes_pkg::pes_stall_t stall,
  // Pipeline side effects
  output logic seqSource,
  output logic uopEmitted,
  output logic [pes_pkg::DELTA_W-1:0] stackDelta,
  output logic [pes_pkg::SP_W-1:0] stackPointer,
  // Counter
  output logic eventHit,
  output logic [pes_pkg::COUNT_W-1:0] eventCount
);
  import pes_pkg::*;

  // Map a code and mask pair to a selection; anything else counts nothing
  function automatic pes_sel_t selectEvent(input logic [7:0] code,
                                           input logic [7:0] mask);
    pes_sel_t sel;
    sel = SEL_NONE;
    unique case (code)
      EV_FP_SIMD: begin
        if (mask == UM_TO_FP) begin
          sel = SEL_TO_FP;
        end else if (mask == UM_TO_SIMD) begin
          sel = SEL_TO_SIMD;
        end else if (mask == UM_ANY_TRANS) begin
          sel = SEL_ANY_TRANS;
        end
      end
      EV_MACRO: begin
        if (mask == UM_DECODED) begin
          sel = SEL_DECODED;
        end
      end
      EV_UOPS: begin
        if (mask == UM_SEQ_UOPS) begin
          sel = SEL_SEQ_UOPS;
        end else if (mask == UM_STACK_FOLD) begin
          sel = SEL_STACK_FOLD;
        end else if (mask == UM_STACK_SYNC) begin
          sel = SEL_STACK_SYNC;
        end
      end
      EV_RAT: begin
        if (mask == UM_FLAG_STALL) begin
          sel = SEL_FLAG_STALL;
        end else if (mask == UM_REG_STALL) begin
          sel = SEL_REG_STALL;
        end else if (mask == UM_ROB_STALL) begin
          sel = SEL_ROB_STALL;
        end else if (mask == UM_SERIAL_STALL) begin
          sel = SEL_SERIAL_STALL;
        end
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  // Widen a one-bit condition into an increment amount
  function automatic logic [UOP_W-1:0] one(input logic cond);
    return cond ? {{(UOP_W-1){1'h0}}, 1'h1} : {UOP_W{1'h0}};
  endfunction

  pes_sel_t evtSel;
  pes_cls_t lastCls;
  pes_cls_t next_lastCls;
  logic [FLAG_W-1:0] lastFlagWrite;
  logic [FLAG_W-1:0] next_lastFlagWrite;
  logic lastPartial;
  logic next_lastPartial;
  logic flagHazardHeld;
  logic next_flagHazardHeld;
  logic [COUNT_W-1:0] next_eventCount;
  logic next_eventHit;

  logic isFp;
  logic isSimdInt;
  logic toFp;
  logic toSimd;
  logic seqUops;
  logic stackFold;
  logic stackSyncOp;
  logic flagWriter;
  logic flagReader;
  logic partialWrite;
  logic flagHazardNow;
  logic flagStallCycle;
  logic regStallCycle;
  logic robStallCycle;
  logic serialStallCycle;
  logic [UOP_W-1:0] seqUopAmount;
  logic [UOP_W-1:0] incAmount;

  assign evtSel = selectEvent(evtCode, unitMask);

  // FP versus SIMD integer transitions; other instructions keep history
  assign isFp = decode.valid && (decode.cls == CLS_FP);
  assign isSimdInt = decode.valid && (decode.cls == CLS_SIMD_INT);
  assign toFp = isFp && (lastCls == CLS_SIMD_INT);
  assign toSimd = isSimdInt && (lastCls == CLS_FP);
  assign next_lastCls = (isFp || isSimdInt) ? decode.cls : lastCls;

  // Long flows and assists come from the microcode sequencer
  assign seqSource = decode.valid &&
                     ((decode.uopCount > SEQ_UOP_LIMIT) || decode.assist);
  assign seqUops = seqSource;
  assign seqUopAmount = seqUops ? decode.uopCount : {UOP_W{1'b0}};

  // Stack adjusts fold into the delta, so no pointer uop goes out
  assign stackFold = decode.valid && decode.stackAdjust;
  assign uopEmitted = decode.valid && !decode.stackAdjust;
  assign stackSyncOp = decode.valid && decode.stackSync;

  // Partial flag write followed by a read of flags it left alone
  assign flagWriter = decode.valid && (decode.flagWrite != FLAG_RST);
  assign flagReader = decode.valid && (decode.flagRead != FLAG_RST);
  assign partialWrite = flagWriter && (decode.flagWrite != FLAGS_ALL);
  assign flagHazardNow = flagReader && lastPartial &&
                         ((decode.flagRead & ~lastFlagWrite) != FLAG_RST);
  assign next_lastFlagWrite = flagWriter ? decode.flagWrite : lastFlagWrite;
  assign next_lastPartial = flagWriter ? partialWrite : lastPartial;
  // Hazard stays armed while the rename stall it caused lasts
  assign next_flagHazardHeld = stall.renameStall &&
                               (flagHazardNow || flagHazardHeld);

  // Stall cycles are counted per cycle, not per event
  assign flagStallCycle = stall.renameStall &&
                          (flagHazardNow || flagHazardHeld);
  assign regStallCycle = stall.partialRegStall;
  // Retries under a lasting port stall count each cycle again
  assign robStallCycle = stall.robPortStall;
  assign serialStallCycle = stall.scoreboardStall;

  always_comb begin
    incAmount = {UOP_W{1'b0}};
    unique case (evtSel)
      SEL_NONE: incAmount = {UOP_W{1'b0}};
      SEL_TO_FP: incAmount = one(toFp);
      SEL_TO_SIMD: incAmount = one(toSimd);
      SEL_ANY_TRANS: incAmount = one(toFp || toSimd);
      SEL_DECODED: incAmount = one(decode.valid);
      SEL_SEQ_UOPS: incAmount = seqUopAmount;
      SEL_STACK_FOLD: incAmount = one(stackFold);
      SEL_STACK_SYNC: incAmount = one(stackSyncOp);
      SEL_FLAG_STALL: incAmount = one(flagStallCycle);
      SEL_REG_STALL: incAmount = one(regStallCycle);
      SEL_ROB_STALL: incAmount = one(robStallCycle);
      SEL_SERIAL_STALL: incAmount = one(serialStallCycle);
    endcase
  end

  // Counter wraps silently; overflow handling lives elsewhere
  assign next_eventHit = countEnable && (incAmount != {UOP_W{1'b0}});
  assign next_eventCount = next_eventHit ?
                           COUNT_W'(eventCount + COUNT_W'(incAmount)) :
                           eventCount;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lastCls <= CLS_OTHER;
      lastFlagWrite <= FLAG_RST;
      lastPartial <= 1'h0;
      flagHazardHeld <= 1'h0;
    end else begin
      lastCls <= next_lastCls;
      lastFlagWrite <= next_lastFlagWrite;
      lastPartial <= next_lastPartial;
      flagHazardHeld <= next_flagHazardHeld;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eventHit <= 1'h0;
      eventCount <= COUNT_RST;
    end else begin
      eventHit <= next_eventHit;
      eventCount <= next_eventCount;
    end
  end

  pes_stack_delta u_stack_delta (
    .core_clk(core_clk),
    .rst(rst),
    .stackAdjust(stackFold),
    .stackStep(decode.stackStep),
    .stackSync(stackSyncOp),
    .stackDelta(stackDelta),
    .stackPointer(stackPointer)
  );

endmodule

// ===== verification/pes_event_select_properties.sv
// Checker for the event select block, bound to its top ports.
// Assumes one core clock and the design package constants.
`timescale 1ns/1ps
module pes_event_select_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Inputs
  input wire logic [7:0] evtCode,
  input wire logic [7:0] unitMask,
  input wire logic countEnable,
  input wire pes_pkg::pes_decode_t decode,
  input wire pes_pkg::pes_stall_t stall,
  // Outputs
  input wire logic seqSource,
  input wire logic uopEmitted,
  input wire logic [15:0] stackDelta,
  input wire logic [31:0] stackPointer,
  input wire logic eventHit,
  input wire logic [47:0] eventCount
);
  import pes_pkg::*;
  wire logic [15:0] sel = {evtCode, unitMask};
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  off_holds_a: assert property (!countEnable |=>
    !eventHit && $stable(eventCount)) else $error("count moved while off");
  unlisted_quiet_a: assert property (sel == 16'hD20F |=> !eventHit)
    else $error("unlisted selection counted");
  decoded_step_a: assert property (countEnable && sel == 16'hD001 &&
    decode.valid |=> eventHit && eventCount == $past(eventCount) + 48'h1)
    else $error("decoded instruction not counted");
  seq_uop_add_a: assert property (countEnable && sel == 16'hD102 &&
    seqSource |=> eventCount == $past(eventCount) + $past(decode.uopCount))
    else $error("sequencer uops not added");
  seq_source_a: assert property (seqSource == (decode.valid &&
    (decode.uopCount > SEQ_UOP_LIMIT || decode.assist)))
    else $error("sequencer source wrong");
  fold_delta_a: assert property (decode.valid && decode.stackAdjust &&
    !decode.stackSync |-> !uopEmitted ##1
    stackDelta == $past(stackDelta) + $past(decode.stackStep))
    else $error("stack fold wrong");
  sync_pointer_a: assert property (decode.valid && decode.stackSync |=>
    $signed(stackPointer - $past(stackPointer)) == $signed($past(stackDelta)))
    else $error("stack sync wrong");
  rob_retry_a: assert property (countEnable && sel == 16'hD204 &&
    stall.robPortStall |=> eventHit) else $error("read port stall missed");
  serial_stall_a: assert property (countEnable && sel == 16'hD208 &&
    stall.scoreboardStall |=> eventHit) else $error("scoreboard missed");

  cover property (eventHit && sel == 16'hCC03);
  cover property (eventHit && sel == 16'hD201);
  cover property (decode.valid && decode.stackSync && decode.stackAdjust);
endmodule

// ===== verification/pes_core_model.sv
// Core pipeline model: random decode and rename stall traffic.
// Assumes it shares the core clock and reset with the block.
`timescale 1ns/1ps
module pes_core_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Strobes to the block
  output pes_pkg::pes_decode_t decode,
  output pes_pkg::pes_stall_t stall
);
  import pes_pkg::*;
  int seed = 32'h0A8914EE;
  logic [31:0] r;
  logic v;
  // Side strobes only with a valid op, so gating choices cannot differ
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      decode <= '0;
      stall <= '0;
    end else begin
      r = $random(seed);
      v = r[0] | r[1];
      decode.valid <= v;
      decode.cls <= pes_cls_t'(r[3:2] == 2'h3 ? 2'h0 : r[3:2]);
      decode.uopCount <= r[7:4] | 4'h1;
      decode.assist <= v & r[8] & r[9];
      decode.stackAdjust <= v & r[10];
      decode.stackStep <= r[11] ? 16'hFFFC : 16'h0004;
      decode.stackSync <= v & r[12] & r[13];
      decode.flagWrite <= v & r[14] ? (r[15] ? 6'h3F : 6'h01) : 6'h00;
      decode.flagRead <= v ? r[21:16] & {6{r[22]}} : 6'h00;
      stall <= pes_stall_t'({r[23] | r[24], r[25], r[26], r[27]});
    end
  end
endmodule

// ===== verification/test_perf_event_select_decode.sv
// Top bench: every selection against a reference model, random traffic.
// Assumes the package, checker and core model are compiled first.
`timescale 1ns/1ps
module test_perf_event_select_decode;
  import pes_pkg::*;
  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] evtCode = 8'h00;
  logic [7:0] unitMask = 8'h00;
  logic countEnable = 1'h0;
  pes_decode_t decode;
  pes_stall_t stall;
  logic seqSource, uopEmitted, eventHit, expHit, held, hz, tFp, tSi;
  logic [15:0] stackDelta, expDelta;
  logic [31:0] stackPointer, expSp;
  logic [47:0] eventCount;
  logic [5:0] pw;
  longint expCount;
  pes_cls_t last;
  int inc;
  int err_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] sels[$] = '{16'hCC01, 16'hCC02, 16'hCC03, 16'hD001, 16'hD102,
    16'hD104, 16'hD108, 16'hD201, 16'hD202, 16'hD204, 16'hD208, 16'hD20F,
    16'h0000};
  wire logic seqExp = decode.valid &&
    (decode.uopCount > SEQ_UOP_LIMIT || decode.assist);

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  pes_core_model core (.core_clk(core_clk), .rst(rst), .decode(decode),
    .stall(stall));
  pes_event_select DUT (.core_clk(core_clk), .rst(rst), .evtCode(evtCode),
    .unitMask(unitMask), .countEnable(countEnable), .decode(decode),
    .stall(stall), .seqSource(seqSource), .uopEmitted(uopEmitted),
    .stackDelta(stackDelta), .stackPointer(stackPointer),
    .eventHit(eventHit), .eventCount(eventCount));

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checked %0d, err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Reference model, evaluated on the inputs of the closing cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      expCount = 0;
      expHit = 1'h0;
      expDelta = 16'h0000;
      expSp = 32'h0000_0000;
      pw = 6'h00;
      held = 1'h0;
      last = CLS_OTHER;
    end else begin
      hz = decode.valid && decode.flagRead != 6'h00 && pw != 6'h00 &&
        (decode.flagRead & ~pw) != 6'h00;
      tFp = decode.valid && decode.cls == CLS_FP && last == CLS_SIMD_INT;
      tSi = decode.valid && decode.cls == CLS_SIMD_INT && last == CLS_FP;
      case ({evtCode, unitMask})
        16'hCC01: inc = tFp;
        16'hCC02: inc = tSi;
        16'hCC03: inc = tFp | tSi;
        16'hD001: inc = decode.valid;
        16'hD102: inc = seqExp ? decode.uopCount : 0;
        16'hD104: inc = decode.valid & decode.stackAdjust;
        16'hD108: inc = decode.valid & decode.stackSync;
        16'hD201: inc = stall.renameStall & (hz | held);
        16'hD202: inc = stall.partialRegStall;
        16'hD204: inc = stall.robPortStall;
        16'hD208: inc = stall.scoreboardStall;
        default: inc = 0;
      endcase
      if (!countEnable)
        inc = 0;
      expHit = inc != 0;
      expCount += inc;
      held = stall.renameStall && (held || hz);
      if (decode.valid && decode.flagWrite != 6'h00)
        pw = decode.flagWrite == 6'h3F ? 6'h00 : decode.flagWrite;
      if (decode.valid && decode.cls != CLS_OTHER)
        last = decode.cls;
      if (decode.valid && decode.stackSync) begin
        expSp += {{16{expDelta[15]}}, expDelta};
        expDelta = decode.stackAdjust ? decode.stackStep : 16'h0000;
      end else if (decode.valid && decode.stackAdjust)
        expDelta += decode.stackStep;
    end
  end

  always @(negedge core_clk) begin
    if (!rst) begin
      check(eventCount, expCount);
      check(eventHit, expHit);
      check(stackDelta, expDelta);
      check(stackPointer, expSp);
      check(seqSource, seqExp);
      check(uopEmitted, decode.valid && !decode.stackAdjust);
    end
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'h0;
    foreach (sels[i]) begin
      if (i == 6) begin
        @(posedge core_clk);
        rst <= 1'h1;
        @(posedge core_clk);
        rst <= 1'h0;
      end
      @(posedge core_clk);
      {evtCode, unitMask} <= sels[i];
      countEnable <= 1'h1;
      repeat (130) @(posedge core_clk);
      countEnable <= 1'h0;
      repeat (20) @(posedge core_clk);
    end
    end_of_test();
  end
endmodule

bind pes_event_select pes_event_select_properties chk (.core_clk(core_clk),
  .rst(rst), .evtCode(evtCode), .unitMask(unitMask),
  .countEnable(countEnable), .decode(decode), .stall(stall),
  .seqSource(seqSource), .uopEmitted(uopEmitted), .stackDelta(stackDelta),
  .stackPointer(stackPointer), .eventHit(eventHit), .eventCount(eventCount));
